// file: common/iis_pkg.sv
/*
 * constants, types and state layout for the involuntary instruction sequencer.
 * assumes: one clock, memory answers a read one cycle after the request,
 * timing pulses arrive as one-cycle strobes carrying the action number.
 */
// What this block does
// - latched interrupt with no higher pending requests entry and supplies one of five vectors.
// - entry writes next-address to word 0024, buffer to 0025, then jumps to vector.
// - save drops bit 15 and copies bit 16 into position 15.
// - entry loads vector as next address, sets in-progress, clears the request.
// - resume reloads buffer from 0025 and next-address from 0024.
// - entry and resume codes made here; resume detected from index address 0025.
// - interrupts taken only at instruction end, never between subinstructions.
// - no interrupt while interrupt-in-progress is set.
// - index 0017 inhibits interrupts until index 0016 releases them.
// - block pulse at action 11 of second index step with buffer underflow blocks.
// - block pulse at action 4, 10 or 11 with accumulator overflow blocks.
// - counter inputs latched; highest priority gets address and one of four ops.
// - counter request may start after any action 12.
// - counter op suspends program; entry request and vector outputs are not masked meanwhile.
// - increment, decrement, shift left, shift left then add one.
// - per counter address, overflow is corrected or reported.
// - request flip-flop cleared when vector moves to the next-address register.
package iis_pkg;

	localparam int          N_INT            = 5;
	localparam int          N_CTR            = 8;
	localparam int          AW               = 12;
	localparam int          DW               = 16;

	// fixed memory words (octal 0024 and 0025)
	localparam logic [11:0] SAVE_Z_ADDR      = 12'h014;
	localparam logic [11:0] SAVE_B_ADDR      = 12'h015;
	// index forms
	localparam logic [11:0] IDX_INHIBIT      = 12'h00f;
	localparam logic [11:0] IDX_RELEASE      = 12'h00e;
	localparam logic [11:0] IDX_RESUME       = 12'h015;
	// first counter (octal 0044), one word per channel
	localparam logic [11:0] CTR_BASE_ADDR    = 12'h024;
	// channels whose overflow is corrected instead of reported
	localparam logic [7:0]  CTR_CORR_MASK    = 8'h0f;

	// vectors 2000, 2010, 2014, 2020, 2024 octal
	localparam logic [N_INT*12-1:0] VECTORS  = {12'h414, 12'h410, 12'h40c, 12'h408, 12'h400};

	// action numbers
	localparam logic [3:0]  ACT_4            = 4'h4;
	localparam logic [3:0]  ACT_10           = 4'ha;
	localparam logic [3:0]  ACT_11           = 4'hb;
	localparam logic [3:0]  ACT_12           = 4'hc;

	// counter op codes
	localparam logic [1:0]  OP_INC           = 2'h0;
	localparam logic [1:0]  OP_DEC           = 2'h1;
	localparam logic [1:0]  OP_SHIFT         = 2'h2;
	localparam logic [1:0]  OP_SHIFT_ONE     = 2'h3;
	localparam logic [15:0] ONE_WORD         = 16'h0001;
	localparam logic [15:0] MINUS_ONE_WORD   = 16'hfffe;

	// apb map
	localparam logic [7:0]  REG_CTRL         = 8'h00;
	localparam logic [7:0]  REG_STATUS       = 8'h04;
	localparam logic [7:0]  REG_IRQ_STAT     = 8'h08;
	localparam logic [7:0]  REG_IRQ_MASK     = 8'h0c;
	localparam logic [1:0]  CTRL_RESET       = 2'h3;
	localparam int          EV_ENTRY         = 0;
	localparam int          EV_RESUME        = 1;
	localparam int          EV_OVERFLOW      = 2;

	typedef enum logic [3:0] {
		ST_IDLE, ST_SAVE_Z, ST_SAVE_B, ST_JUMP,
		ST_RD_B, ST_RD_Z, ST_RS_DONE,
		ST_C_RD, ST_C_CALC, ST_C_WR
	} iis_state_t;

	typedef struct packed {
		logic          req;
		logic          we;
		logic [11:0]   addr;
		logic [15:0]   wdata;
	} iis_mem_t;

	typedef struct packed {
		iis_state_t    st;
		logic [4:0]    int_pend;
		logic [2:0]    int_sel;
		logic          inprog;
		logic          inhibit;
		logic          blk;
		logic [7:0]    ctr_pend;
		logic [15:0]   ctr_kind;
		logic [2:0]    ctr_sel;
		iis_mem_t      mem;
		logic          z_load;
		logic          b_load;
		logic [15:0]   load_data;
		logic          interrupt_entry_instr_req;
		logic [11:0]   interrupt_entry_instr_vec;
		logic          suspend;
		logic          ctr_ovf;
		logic          pready;
		logic [31:0]   prdata;
		logic          pslverr;
		logic [1:0]    ctrl;
		logic [2:0]    irq_stat;
		logic [2:0]    irq_mask;
		logic          irq;
	} iis_state_reg_t;

endpackage : iis_pkg

// file: src/iis_top.sv
/*
 * involuntary instruction sequencer: interrupt entry and resume, counter
 * updates between subinstructions, apb control and status.
 * assumes: timing strobes and request pulses synchronous to pclk; memory
 * read data valid the cycle after mem.req; cpu honours suspend.
 */
// Design decisions made here: the address map and the APB slave port.
`timescale 1ns/1ps

module iis_top (
	// clock and reset
	input  wire logic                pclk,
	input  wire logic                presetn,
	// apb slave
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [7:0]          paddr,
	input  wire logic [31:0]         pwdata,
	output logic                     pready,
	output logic [31:0]              prdata,
	output logic                     pslverr,
	output logic                     irq,
	// processor timing
	input  wire logic                act_strobe,
	input  wire logic [3:0]          act_num,
	input  wire logic                instr_end,
	input  wire logic                index_second_step,
	input  wire logic                interrupt_block_pulse,
	input  wire logic                acc_overflow,
	input  wire logic                buf_underflow,
	input  wire logic                idx_valid,
	input  wire logic [11:0]         idx_addr,
	// next-address and buffer registers
	input  wire logic [15:0]         z_value,
	input  wire logic [15:0]         b_value,
	output logic                     z_load,
	output logic                     b_load,
	output logic [15:0]              load_data,
	// requests
	input  wire logic [4:0]          int_in,
	input  wire logic [7:0]          ctr_in,
	input  wire logic [15:0]         ctr_in_kind,
	// memory
	output iis_pkg::iis_mem_t        mem,
	input  wire logic [15:0]         mem_rdata,
	// sequencer status
	output logic                     interrupt_entry_instr_request,
	output logic [11:0]              interrupt_entry_instr_vector,
	output logic                     suspend,
	output logic                     in_progress,
	output logic                     ctr_overflow
);

	iis_pkg::iis_state_reg_t r;
	iis_pkg::iis_state_reg_t n;

	////////////////////////////////////////////////////////////////////////////
	// helpers

	// bit 15 lost, bit 16 kept twice
	function automatic logic [15:0] iis_pack(input logic [15:0] w);
		return {w[15], w[15], w[13:0]};
	endfunction : iis_pack

	// ones complement add with end-around carry
	function automatic logic [15:0] iis_add(input logic [15:0] a, input logic [15:0] b);
		logic [16:0] s;
		s = {1'b0, a} + {1'b0, b};
		return s[15:0] + {15'h0000, s[16]};
	endfunction : iis_add

	// counter update: {overflow to report, new word}; overflow when bits 15 and 14 differ
	function automatic logic [16:0] iis_ctr_op(input logic [1:0] op, input logic [15:0] w,
		input logic corr);
		logic [15:0] v;
		logic        ovf;
		unique case (op)
			iis_pkg::OP_INC:   v = iis_add(w, iis_pkg::ONE_WORD);
			iis_pkg::OP_DEC:   v = iis_add(w, iis_pkg::MINUS_ONE_WORD);
			iis_pkg::OP_SHIFT: v = {w[14:0], 1'b0};
			iis_pkg::OP_SHIFT_ONE: v = {w[14:0], 1'b1};
		endcase
		ovf = v[15] ^ v[14];
		if (corr && ovf)
			v[15] = v[14];
		return {ovf & ~corr, v};
	endfunction : iis_ctr_op

	////////////////////////////////////////////////////////////////////////////
	// next state

	logic        int_any;
	logic [2:0]  int_pick;
	logic        ctr_any;
	logic [2:0]  ctr_pick;
	logic        may_interrupt_entry_instr;
	logic        act12;
	logic        apb_wr;
	logic [16:0] op_res;
	logic [2:0]  ev;

	always_comb
	begin
		n        = r;
		int_any  = 1'b0;
		int_pick = 3'h0;
		ctr_any  = 1'b0;
		ctr_pick = 3'h0;
		ev       = 3'h0;
		op_res   = 17'h00000;
		act12    = act_strobe && (act_num == iis_pkg::ACT_12);
		apb_wr   = psel && penable && r.pready && pwrite;

		n.mem.req = 1'b0;
		n.mem.we  = 1'b0;
		n.z_load  = 1'b0;
		n.b_load  = 1'b0;
		n.ctr_ovf = 1'b0;

		////////////////////////////////////////////////////////////////////////////
		// priority pick, highest first
		// lowest index wins
		for (int i = iis_pkg::N_INT - 1; i >= 0; i--)
		begin
			if (r.int_pend[i])
			begin
				int_any  = 1'b1;
				int_pick = 3'(i);
			end
		end
		for (int i = iis_pkg::N_CTR - 1; i >= 0; i--)
		begin
			if (r.ctr_pend[i])
			begin
				ctr_any  = 1'b1;
				ctr_pick = 3'(i);
			end
		end

		////////////////////////////////////////////////////////////////////////////
		// interrupt gating
		// gated by in-progress, inhibit, block and the interrupt enable bit ctrl[0]
		may_interrupt_entry_instr = int_any && !r.inprog && !r.inhibit && !r.blk && r.ctrl[0];
		n.interrupt_entry_instr_req = may_interrupt_entry_instr;
		n.interrupt_entry_instr_vec = iis_pkg::VECTORS[int_pick*12 +: 12];

		// inhibit and release by index form
		if (idx_valid && idx_addr == iis_pkg::IDX_INHIBIT)
			n.inhibit = 1'b1;
		if (idx_valid && idx_addr == iis_pkg::IDX_RELEASE)
			n.inhibit = 1'b0;

		// block clears at instruction end, a later pulse sets again
		// a pulse in the end cycle itself carries the block into the next instruction
		if (instr_end)
			n.blk = 1'b0;
		if (interrupt_block_pulse && act_strobe)
		begin
			if (acc_overflow && (act_num == iis_pkg::ACT_4 || act_num == iis_pkg::ACT_10
				|| act_num == iis_pkg::ACT_11))
				n.blk = 1'b1;
			if (index_second_step && buf_underflow && act_num == iis_pkg::ACT_11)
				n.blk = 1'b1;
		end

		////////////////////////////////////////////////////////////////////////////
		// involuntary sequences
		// one sequence at a time; a request arriving mid-sequence waits in its latch
		unique case (r.st)
			iis_pkg::ST_IDLE:
			begin
				// counter first: it steals three cycles, an entry would hold it off longer
				// counter slot after any action 12
				if (act12 && ctr_any && r.ctrl[1])
				begin
					n.st       = iis_pkg::ST_C_RD;
					n.ctr_sel  = ctr_pick;
					n.suspend  = 1'b1;
					n.mem.req  = 1'b1;
					n.mem.addr = iis_pkg::CTR_BASE_ADDR + {9'h000, ctr_pick};
				end
				else if (instr_end && may_interrupt_entry_instr)
				begin
					n.st       = iis_pkg::ST_SAVE_Z;
					n.int_sel  = int_pick;
					n.suspend  = 1'b1;
					// next address to first save word
					n.mem.req  = 1'b1;
					n.mem.we   = 1'b1;
					n.mem.addr = iis_pkg::SAVE_Z_ADDR;
					n.mem.wdata = iis_pack(z_value);
				end
				else if (idx_valid && idx_addr == iis_pkg::IDX_RESUME)
				begin
					n.st       = iis_pkg::ST_RD_B;
					n.suspend  = 1'b1;
					n.mem.req  = 1'b1;
					n.mem.addr = iis_pkg::SAVE_B_ADDR;
				end
			end
			iis_pkg::ST_SAVE_Z:
			begin
				n.st        = iis_pkg::ST_SAVE_B;
				n.mem.req   = 1'b1;
				n.mem.we    = 1'b1;
				n.mem.addr  = iis_pkg::SAVE_B_ADDR;
				n.mem.wdata = iis_pack(b_value);
			end
			iis_pkg::ST_SAVE_B:
			begin
				n.st        = iis_pkg::ST_JUMP;
				n.z_load    = 1'b1;
				n.load_data = {4'h0, iis_pkg::VECTORS[r.int_sel*12 +: 12]};
				n.inprog    = 1'b1;
				n.int_pend[r.int_sel] = 1'b0;
			end
			iis_pkg::ST_JUMP:
			begin
				n.st      = iis_pkg::ST_IDLE;
				n.suspend = 1'b0;
				ev[iis_pkg::EV_ENTRY] = 1'b1;
			end
			iis_pkg::ST_RD_B:
			begin
				n.st       = iis_pkg::ST_RD_Z;
				n.mem.req  = 1'b1;
				n.mem.addr = iis_pkg::SAVE_Z_ADDR;
			end
			iis_pkg::ST_RD_Z:
			begin
				n.st        = iis_pkg::ST_RS_DONE;
				// buffer word asked for last cycle is on mem_rdata now
				// buffer reloaded
				n.b_load    = 1'b1;
				n.load_data = mem_rdata;
			end
			iis_pkg::ST_RS_DONE:
			begin
				n.st        = iis_pkg::ST_IDLE;
				n.z_load    = 1'b1;
				n.load_data = mem_rdata;
				n.inprog    = 1'b0;
				n.suspend   = 1'b0;
				ev[iis_pkg::EV_RESUME] = 1'b1;
			end
			iis_pkg::ST_C_RD:
				// memory answers one cycle after the request
				n.st = iis_pkg::ST_C_CALC;
			iis_pkg::ST_C_CALC:
			begin
				op_res      = iis_ctr_op(r.ctr_kind[r.ctr_sel*2 +: 2], mem_rdata,
					iis_pkg::CTR_CORR_MASK[r.ctr_sel]);
				n.st        = iis_pkg::ST_C_WR;
				n.mem.req   = 1'b1;
				n.mem.we    = 1'b1;
				n.mem.wdata = op_res[15:0];
				n.ctr_ovf   = op_res[16];
				ev[iis_pkg::EV_OVERFLOW] = op_res[16];
				n.ctr_pend[r.ctr_sel] = 1'b0;
			end
			iis_pkg::ST_C_WR:
			begin
				n.st      = iis_pkg::ST_IDLE;
				n.suspend = 1'b0;
			end
			default:
				// unused state codes fall back to idle
				n.st = iis_pkg::ST_IDLE;
		endcase

		////////////////////////////////////////////////////////////////////////////
		// request latches, after the case so a fresh pulse beats its own clear
		// latch every counter input; set wins over clear
		for (int i = 0; i < iis_pkg::N_CTR; i++)
		begin
			if (ctr_in[i])
			begin
				n.ctr_pend[i]       = 1'b1;
				n.ctr_kind[i*2 +: 2] = ctr_in_kind[i*2 +: 2];
			end
		end
		for (int i = 0; i < iis_pkg::N_INT; i++)
		begin
			if (int_in[i])
				n.int_pend[i] = 1'b1;
		end

		////////////////////////////////////////////////////////////////////////////
		// apb access
		// reads decode in setup, so status shows the setup-cycle state
		// apb: answer ready in the first access cycle
		n.pready  = psel && !penable;
		n.pslverr = 1'b0;
		if (psel && !penable)
		begin
			n.prdata = 32'h00000000;
			unique case (paddr)
				iis_pkg::REG_CTRL:     n.prdata = {30'h00000000, r.ctrl};
				iis_pkg::REG_STATUS:   n.prdata = {9'h000, r.ctr_pend, 3'h0, r.int_pend,
					r.st, r.blk, r.inhibit, r.inprog};
				iis_pkg::REG_IRQ_STAT: n.prdata = {29'h00000000, r.irq_stat};
				iis_pkg::REG_IRQ_MASK: n.prdata = {29'h00000000, r.irq_mask};
				default:               n.pslverr = 1'b1;
			endcase
		end
		if (apb_wr && paddr == iis_pkg::REG_CTRL)
			n.ctrl = pwdata[1:0];
		if (apb_wr && paddr == iis_pkg::REG_IRQ_MASK)
			n.irq_mask = pwdata[2:0];
		// write one to clear; new event wins
		if (apb_wr && paddr == iis_pkg::REG_IRQ_STAT)
			n.irq_stat = r.irq_stat & ~pwdata[2:0];
		n.irq_stat = n.irq_stat | ev;
		n.irq      = |(n.irq_stat & n.irq_mask);
	end

	////////////////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			// whole state cleared, then the fields that are not zero at reset
			r       <= '0;
			r.st    <= iis_pkg::ST_IDLE;
			r.ctrl  <= iis_pkg::CTRL_RESET;
		end
		else
		begin
			r <= n;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs, all from flops

	assign pready       = r.pready;
	assign prdata       = r.prdata;
	assign pslverr      = r.pslverr;
	assign irq          = r.irq;
	assign z_load       = r.z_load;
	assign b_load       = r.b_load;
	assign load_data    = r.load_data;
	// one registered struct, so strobe, address and data never skew
	assign mem          = r.mem;
	assign interrupt_entry_instr_request = r.interrupt_entry_instr_req;
	assign interrupt_entry_instr_vector  = r.interrupt_entry_instr_vec;
	assign suspend      = r.suspend;
	assign in_progress  = r.inprog;
	assign ctr_overflow = r.ctr_ovf;

endmodule : iis_top

// file: sim/iis_top_properties.sv
/* checker: timing of entry, resume and counter sequences at the top ports.
   assumes: bound to iis_top, one clock domain, memory port as in the package. */
`timescale 1ns/1ps

module iis_top_properties (
	// clock and reset
	input wire logic              pclk,
	input wire logic              presetn,
	// observed
	input wire logic              act_strobe,
	input wire logic [3:0]        act_num,
	input wire logic              instr_end,
	input wire logic [15:0]       z_value,
	input wire iis_pkg::iis_mem_t mem,
	input wire logic              z_load,
	input wire logic              b_load,
	input wire logic              in_progress,
	input wire logic              suspend
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	wire rd   = mem.req && !mem.we;
	wire sv_z = mem.req && mem.we && mem.addr == iis_pkg::SAVE_Z_ADDR;
	wire sv_b = mem.req && mem.we && mem.addr == iis_pkg::SAVE_B_ADDR;
	wire rd_z = rd && mem.addr == iis_pkg::SAVE_Z_ADDR;
	wire rd_b = rd && mem.addr == iis_pkg::SAVE_B_ADDR;
	// channel words sit in one block of eight above the base
	wire c_rd = rd && mem.addr >= iis_pkg::CTR_BASE_ADDR
		&& mem.addr < iis_pkg::CTR_BASE_ADDR + 12'h008;

	a_save_order: assert property (sv_z |=> sv_b)
		else $error("buffer save does not follow next-address save");
	a_save_bits: assert property (sv_z |-> mem.wdata ==
		{$past(z_value[15]), $past(z_value[15]), $past(z_value[13:0])})
		else $error("saved next-address word has wrong bits");
	a_entry_jump: assert property (sv_b |=> z_load && in_progress)
		else $error("vector load or in-progress missing after save");
	a_entry_edge: assert property (sv_z |-> $past(instr_end))
		else $error("entry started away from an instruction end");
	a_no_nest: assert property (sv_z |-> !$past(in_progress))
		else $error("entry taken while in progress");
	a_resume_walk: assert property (rd_b |=> rd_z ##1 b_load
		##1 (z_load && !in_progress))
		else $error("resume reload order broken");
	a_ctr_start: assert property (c_rd |->
		$past(act_strobe && act_num == iis_pkg::ACT_12))
		else $error("counter read not after action 12");
	a_ctr_suspend: assert property (c_rd |-> suspend ##2
		(mem.req && mem.we && mem.addr == $past(mem.addr, 2) && suspend))
		else $error("counter update not suspended or misplaced");

	c_entry: cover property (sv_z);
	c_resume: cover property (rd_b);
	c_ctr: cover property (c_rd);
endmodule : iis_top_properties

bind iis_top iis_top_properties i_iis_top_properties (.pclk, .presetn, .act_strobe,
	.act_num, .instr_end, .z_value, .mem, .z_load, .b_load, .in_progress, .suspend);

// file: sim/iis_mem_model.sv
/* partner: word memory behind the sequencer's memory port.
   assumes: read data wanted in the cycle after the request. */
`timescale 1ns/1ps

module iis_mem_model (
	// clock
	input wire logic              pclk,
	// memory port
	input wire iis_pkg::iis_mem_t mem,
	output logic [15:0]           mem_rdata
);
	logic [15:0] words [0:4095];

	initial mem_rdata = 16'h0000;

	always @(posedge pclk)
	begin
		if (mem.req && !mem.we)
			mem_rdata <= words[mem.addr];
		else
			mem_rdata <= ~mem_rdata; // released bus, no stale word
		if (mem.req && mem.we)
			words[mem.addr] <= mem.wdata;
	end
endmodule : iis_mem_model

// file: sim/involuntary_instr_sequencer_bench.sv
/* bench: entry, blocking, resume, counter and apb traffic against a queue model.
   assumes: package, iis_top, checker and memory model compiled first. */
`timescale 1ns/1ps

module involuntary_instr_sequencer_bench;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic        act_strobe = 0, instr_end = 0, index_second_step = 0;
	logic        interrupt_block_pulse = 0, acc_overflow = 0, buf_underflow = 0;
	logic        idx_valid = 0, pready, pslverr, irq, z_load, b_load, er, ov;
	logic        interrupt_entry_instr_request, suspend, in_progress, ctr_overflow;
	logic [3:0]  act_num = 0;
	logic [4:0]  int_in = 0;
	logic [7:0]  paddr = 0, ctr_in = 0;
	logic [11:0] idx_addr = 0, interrupt_entry_instr_vector;
	logic [15:0] z_value = 0, b_value = 0, ctr_in_kind = 0, load_data, mem_rdata;
	logic [15:0] zs, bs, cw, res;
	logic [31:0] pwdata = 0, prdata, rd;
	logic [28:0] e;
	logic [28:0] exp_q [$];
	logic [3:0]  acts [5] = '{4'h0, 4'h4, 4'ha, 4'hb, 4'hb};
	int          fails = 0, tests_run = 0, seed = 55769, k, ch;
	iis_pkg::iis_mem_t mem;

	iis_top i_iis_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pready, .prdata, .pslverr, .irq, .act_strobe, .act_num, .instr_end,
		.index_second_step, .interrupt_block_pulse, .acc_overflow, .buf_underflow,
		.idx_valid, .idx_addr, .z_value, .b_value, .z_load, .b_load, .load_data,
		.int_in, .ctr_in, .ctr_in_kind, .mem, .mem_rdata, .interrupt_entry_instr_request,
		.interrupt_entry_instr_vector, .suspend, .in_progress, .ctr_overflow);
	iis_mem_model i_iis_mem_model (.pclk, .mem, .mem_rdata);

	always #10 pclk = ~pclk;

	////////////////////////////////////////////////////////////////////////////
	task print_verdict;
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : print_verdict

	task lost;
		fails++;
		print_verdict();
	endtask : lost

	task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp)
		begin
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
			fails++;
		end
	endtask : chk

	task step(input int n);
		repeat (n) @(posedge pclk);
	endtask : step

	function automatic logic [15:0] oc_add(input logic [15:0] a, input logic [15:0] b);
		logic [16:0] s;
		s = a + b;
		return s[15:0] + {15'h0, s[16]}; // end-around carry
	endfunction : oc_add

	// idle cycle after release so psel is never driven twice in one step
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		step(1);
		penable <= 1'b1;
		for (i = 0; i < 9; i++)
		begin
			step(1);
			if (pready === 1'b1)
				break;
		end
		if (i == 9)
			lost();
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		step(1);
	endtask : apb

	task wait_load(input logic isb, input logic [15:0] d, input logic ip);
		int i;
		for (i = 0; i < 9; i++)
		begin
			@(negedge pclk);
			if ((z_load | b_load) === 1'b1)
				break;
		end
		if (i == 9)
			lost();
		chk("b_load", isb, b_load);
		chk("load_data", d, load_data);
		chk("in_progress", ip, in_progress);
		step(1);
	endtask : wait_load

	task entry(input logic [11:0] v);
		exp_q.push_back({1'b0, iis_pkg::SAVE_Z_ADDR, zs});
		exp_q.push_back({1'b0, iis_pkg::SAVE_B_ADDR, bs});
		instr_end <= 1'b1;
		step(1);
		instr_end <= 1'b0;
		wait_load(1'b0, {4'h0, v}, 1'b1);
	endtask : entry

	task resume;
		idx_addr <= iis_pkg::IDX_RESUME;
		idx_valid <= 1'b1;
		step(1);
		idx_valid <= 1'b0;
		wait_load(1'b1, bs, 1'b1);
		wait_load(1'b0, zs, 1'b0);
	endtask : resume

	always @(negedge pclk)
		if (mem.req === 1'b1 && mem.we === 1'b1)
		begin
			e = (exp_q.size() > 0) ? exp_q.pop_front() : '1;
			chk("mem_write", e, {ctr_overflow, mem.addr, mem.wdata});
		end

	////////////////////////////////////////////////////////////////////////////
	initial
	begin
		step(2);
		presetn <= 1'b1;
		step(1);
		apb(1'b0, iis_pkg::REG_CTRL, 32'h0);
		chk("ctrl", {30'h0, iis_pkg::CTRL_RESET}, rd);
		apb(1'b0, 8'h10, 32'h0);
		chk("pslverr", 1'b1, er);
		apb(1'b1, iis_pkg::REG_IRQ_MASK, 32'h7);
		apb(1'b0, iis_pkg::REG_IRQ_MASK, 32'h0);
		chk("irq_mask", 32'h7, rd);
		z_value <= 16'($random(seed));
		b_value <= 16'($random(seed));
		int_in <= 5'h14;
		step(1);
		int_in <= 5'h00;
		zs = {z_value[15], z_value[15], z_value[13:0]};
		bs = {b_value[15], b_value[15], b_value[13:0]};
		step(1);
		@(negedge pclk);
		chk("interrupt_entry_instr_vector", 12'h40c, interrupt_entry_instr_vector);
		chk("interrupt_entry_instr_request", 1'b1, interrupt_entry_instr_request);
		step(1);
		entry(12'h40c);
		instr_end <= 1'b1;
		step(1);
		instr_end <= 1'b0;
		step(5);
		@(negedge pclk);
		chk("in_progress", 1'b1, in_progress);
		chk("interrupt_entry_instr_vector", 12'h414, interrupt_entry_instr_vector);
		chk("interrupt_entry_instr_request", 1'b0, interrupt_entry_instr_request);
		chk("irq", 1'b1, irq);
		step(1);
		apb(1'b0, iis_pkg::REG_IRQ_STAT, 32'h0);
		chk("irq_stat", 32'h1, rd);
		apb(1'b1, iis_pkg::REG_IRQ_STAT, 32'h1);
		step(1);
		@(negedge pclk);
		chk("irq", 1'b0, irq);
		step(1);
		resume();
		// inhibit first, then each block pulse; release rides along
		for (k = 0; k < 5; k++)
		begin
			idx_addr <= (k == 0) ? iis_pkg::IDX_INHIBIT : iis_pkg::IDX_RELEASE;
			idx_valid <= 1'b1;
			acc_overflow <= (k > 0 && k < 4);
			index_second_step <= (k == 4);
			buf_underflow <= (k == 4);
			act_strobe <= (k > 0);
			act_num <= acts[k];
			interrupt_block_pulse <= (k > 0);
			step(1);
			idx_valid <= 1'b0;
			act_strobe <= 1'b0;
			interrupt_block_pulse <= 1'b0;
			instr_end <= 1'b1;
			step(1);
			instr_end <= 1'b0;
			step(4);
			@(negedge pclk);
			chk("in_progress", 1'b0, in_progress);
			step(1);
			if (k == 0)
			begin
				apb(1'b0, iis_pkg::REG_STATUS, 32'h0);
				chk("status", 32'h00000802, rd);
			end
		end
		entry(12'h414);
		resume();
		for (k = 0; k < 8; k++)
		begin
			ch = (k < 4) ? 5 : 1;
			cw = (k[1:0] == 2'h0) ? 16'h3fff : 16'($random(seed));
			i_iis_mem_model.words[12'(iis_pkg::CTR_BASE_ADDR + ch)] = cw;
			case (k[1:0])
				2'h0: res = oc_add(cw, 16'h0001);
				2'h1: res = oc_add(cw, 16'hfffe);
				2'h2: res = {cw[14:0], 1'b0};
				default: res = oc_add({cw[14:0], 1'b0}, 16'h0001);
			endcase
			ov = res[15] ^ res[14];
			if (ch < 4)
			begin
				res[15] = res[14];
				ov = 1'b0;
			end
			exp_q.push_back({ov, 12'(iis_pkg::CTR_BASE_ADDR + ch), res});
			ctr_in_kind <= 16'(k[1:0]) << (2 * ch);
			ctr_in <= 8'h01 << ch;
			step(1);
			ctr_in <= 8'h00;
			act_num <= iis_pkg::ACT_12;
			act_strobe <= 1'b1;
			step(1);
			act_strobe <= 1'b0;
			step(5);
		end
		@(negedge pclk);
		chk("irq", 1'b1, irq);
		step(1);
		apb(1'b1, iis_pkg::REG_IRQ_MASK, 32'h0);
		step(1);
		@(negedge pclk);
		chk("irq", 1'b0, irq);
		step(1);
		apb(1'b0, iis_pkg::REG_IRQ_STAT, 32'h0);
		chk("irq_stat", 32'h7, rd);
		apb(1'b1, iis_pkg::REG_IRQ_STAT, 32'h7);
		apb(1'b1, iis_pkg::REG_IRQ_MASK, 32'h7);
		// interrupt enable off: request held back, vector still tracks
		apb(1'b1, iis_pkg::REG_CTRL, 32'h0);
		int_in <= 5'h01;
		step(1);
		int_in <= 5'h00;
		step(1);
		@(negedge pclk);
		chk("interrupt_entry_instr_request", 1'b0, interrupt_entry_instr_request);
		chk("interrupt_entry_instr_vector", 12'h400, interrupt_entry_instr_vector);
		step(1);
		apb(1'b1, iis_pkg::REG_CTRL, 32'h3);
		@(negedge pclk);
		chk("interrupt_entry_instr_request", 1'b1, interrupt_entry_instr_request);
		step(1);
		@(negedge pclk);
		chk("irq", 1'b0, irq);
		chk("queue", 32'h0, exp_q.size());
		print_verdict();
	end
endmodule : involuntary_instr_sequencer_bench
